// File: hw/sar_adc_autocal_sequencer.v
// Purpose: digital sequencer of a 16-bit charge-redistribution converter
// Assumes: analog comparator and capacitor array clocked by clk
// Notes:   calRequest is an asynchronous reset of the whole sequencer
`timescale 1ns/1ps
`include "sar_adc_autocal_map.vh"
`default_nettype none

module sar_adc_autocal_sequencer #(
    parameter [`CAL_CNT_BITS-1:0]  CAL_CYCLES  = `CAL_CYCLES,
    parameter [`STEP_CNT_BITS-1:0] STEP_CYCLES = `STEP_CYCLES
) (
    input  wire                      clk,
    input  wire                      sys_rst,
    input  wire                      calRequest,
    input  wire                      acquire,
    input  wire                      compHigh,
    output reg                       busy,
    output reg                       serial_data_out,
    output reg                       serialClk,
    output reg                       sampleHold,
    output reg                       groundSenseSel,
    output reg                       chargeToRef,
    output reg  [`STEP_BITS-1:0]     capSelect,
    output reg  [`CAL_BITS-1:0]      calDacCode,
    output reg  [`RESULT_BITS-1:0]   dacWord,
    output reg  [`RESULT_BITS-1:0]   resultWord,
    output reg                       resultValid
);

    // ---------------------------------------------------------------
    // reset and acquire input
    // ---------------------------------------------------------------
    // release is not synchronised: calRequest must fall clear of an edge
    wire anyRst = sys_rst | calRequest;

    reg acqS1, acqS2, acqS3, acqLevel;
    always @(posedge clk or posedge anyRst) begin
        if (anyRst) begin
            acqS1    <= 1'b0;
            acqS2    <= 1'b0;
            acqS3    <= 1'b0;
            acqLevel <= 1'b0;
        end else begin
            acqS1 <= acquire;
            acqS2 <= acqS1;
            acqS3 <= acqS2;
            if (acqS2 == acqS3)
                acqLevel <= acqS3;
        end
    end
    wire acqFall = acqLevel & ~acqS2 & ~acqS3;

    // ---------------------------------------------------------------
    // correction memory and applied result
    // ---------------------------------------------------------------
    reg  signed [`CAL_BITS-1:0] corrMem [0:`CAL_STEPS-1];
    reg  [`RESULT_BITS-1:0]     sarWord;
    reg  [`RESULT_BITS-1:0]     sarMask;
    wire [`RESULT_BITS-1:0]     decided =
        (compHigh ? sarWord : (sarWord & ~sarMask));

    wire signed [`RESULT_BITS+1:0] partial [0:`CAL_STEPS-1];
    assign partial[0] = $signed({2'b00, decided})
                      - {{(`RESULT_BITS-`CAL_BITS+2){corrMem[0][`CAL_BITS-1]}},
                         corrMem[0]};
    genvar k;
    generate
        for (k = 1; k < `CAL_STEPS; k = k + 1) begin : g_corr
            // slot k holds the mismatch of bit 16-k
            assign partial[k] = partial[k-1] + (decided[`RESULT_BITS-k] ?
                {{(`RESULT_BITS-`CAL_BITS+2){corrMem[k][`CAL_BITS-1]}},
                 corrMem[k]} : {(`RESULT_BITS+2){1'b0}});
        end
    endgenerate
    // no saturation: out-of-range corrections wrap
    wire [`RESULT_BITS-1:0] corrected =
        partial[`CAL_STEPS-1][`RESULT_BITS-1:0] ^ `SIGN_FLIP;

    // ---------------------------------------------------------------
    // single controller
    // ---------------------------------------------------------------
    reg [`ST_BITS-1:0]       state;
    reg [`CAL_CNT_BITS-1:0]  calCount;
    reg [`STEP_CNT_BITS-1:0] slotCount;
    reg [`STEP_BITS-1:0]     stepIdx;
    reg [`CAL_BITS-1:0]      calMask;
    reg [4:0]                convCount;
    reg [`RESULT_BITS-1:0]   shiftReg;
    reg [4:0]                shiftLeft;

    wire [`CAL_BITS-1:0] calTop  = {1'b1, {(`CAL_BITS-1){1'b0}}};
    wire [`CAL_BITS-1:0] calKeep =
        compHigh ? calDacCode : (calDacCode & ~calMask);
    wire stepsLeft = (stepIdx < `CAL_STEPS);
    wire storeNow  = stepsLeft && (calMask == {{(`CAL_BITS-1){1'b0}}, 1'b1});

    always @(posedge clk) begin
        if (state == `ST_CAL && storeNow)
            corrMem[stepIdx] <= calKeep;
    end

    always @(posedge clk or posedge anyRst) begin
        if (anyRst) begin
            state           <= `ST_CAL;
            busy            <= 1'b1;
            calCount        <= {`CAL_CNT_BITS{1'b0}};
            slotCount       <= {`STEP_CNT_BITS{1'b0}};
            stepIdx         <= `OFFSET_SLOT;
            calMask         <= {1'b1, {(`CAL_BITS-1){1'b0}}};
            calDacCode      <= {1'b1, {(`CAL_BITS-1){1'b0}}};
            groundSenseSel  <= 1'b1;
            chargeToRef     <= 1'b0;
            capSelect       <= `OFFSET_SLOT;
            serial_data_out <= 1'b0;
            serialClk       <= 1'b0;
            sampleHold      <= 1'b0;
            sarWord         <= {`RESULT_BITS{1'b0}};
            sarMask         <= {`RESULT_BITS{1'b0}};
            dacWord         <= {`RESULT_BITS{1'b0}};
            resultWord      <= {`RESULT_BITS{1'b0}};
            resultValid     <= 1'b0;
            convCount       <= 5'h00;
            shiftReg        <= {`RESULT_BITS{1'b0}};
            shiftLeft       <= 5'h00;
        end else begin
            case (state)
            `ST_CAL: begin
                calCount <= calCount + 1'b1;
                // diagnostic stream: comparator decisions, no user meaning
                if (acqLevel) begin
                    serial_data_out <= compHigh;
                    serialClk       <= ~serialClk;
                end else begin
                    serialClk <= 1'b0;
                end
                if (stepsLeft) begin
                    if (calMask != {`CAL_BITS{1'b0}}) begin
                        calDacCode <= calKeep | (calMask >> 1);
                        calMask    <= calMask >> 1;
                    end
                    chargeToRef <= 1'b0;
                    if (slotCount == STEP_CYCLES - 1'b1) begin
                        slotCount      <= {`STEP_CNT_BITS{1'b0}};
                        stepIdx        <= stepIdx + 1'b1;
                        groundSenseSel <= 1'b0;
                        // past the last capacitor the select parks at zero
                        capSelect      <= (stepIdx + 1'b1 < `CAL_STEPS) ?
                            stepIdx + 1'b1 : `OFFSET_SLOT;
                        chargeToRef    <= (stepIdx + 1'b1 < `CAL_STEPS);
                        calMask        <= calTop;
                        calDacCode     <= calTop;
                    end else begin
                        slotCount <= slotCount + 1'b1;
                    end
                end else begin
                    capSelect <= `OFFSET_SLOT;
                end
                if (calCount == CAL_CYCLES - 1'b1) begin
                    state       <= `ST_IDLE;
                    busy        <= 1'b0;
                    resultValid <= 1'b1;
                    serialClk   <= 1'b0;
                    capSelect   <= `OFFSET_SLOT;
                end
            end
            `ST_IDLE: begin
                sampleHold <= 1'b0;
                if (shiftLeft != 5'h00) begin
                    serialClk <= ~serialClk;
                    if (serialClk) begin
                        shiftReg  <= shiftReg << 1;
                        shiftLeft <= shiftLeft - 1'b1;
                    end
                    serial_data_out <= serialClk ?
                        shiftReg[`RESULT_BITS-2] : shiftReg[`RESULT_BITS-1];
                end else begin
                    serialClk <= 1'b0;
                end
                if (acqFall) begin
                    state      <= `ST_CONV;
                    busy       <= 1'b1;
                    sampleHold <= 1'b1;
                    sarWord    <= `SIGN_FLIP;
                    sarMask    <= `SIGN_FLIP;
                    dacWord    <= `SIGN_FLIP;
                    convCount  <= 5'h00;
                    shiftLeft  <= 5'h00;
                    serialClk  <= 1'b0;
                end
            end
            `ST_CONV: begin
                // one bit per pulse after the entry pulse
                sarWord   <= decided | (sarMask >> 1);
                dacWord   <= decided | (sarMask >> 1);
                sarMask   <= sarMask >> 1;
                convCount <= convCount + 1'b1;
                if (convCount == `CONV_DECIDES - 1'b1) begin
                    state      <= `ST_IDLE;
                    busy       <= 1'b0;
                    sampleHold <= 1'b0;
                    resultWord <= corrected;
                    shiftReg   <= corrected;
                    shiftLeft  <= `CONV_DECIDES;
                    serial_data_out <= corrected[`RESULT_BITS-1];
                end
            end
            default: begin
                state <= `ST_IDLE;
                busy  <= 1'b0;
            end
            endcase
        end
    end

endmodule // sar_adc_autocal_sequencer

`default_nettype wire

// File: hw/sar_adc_autocal_map.vh
// Purpose: constants for the converter sequencer
// Assumes: plain Verilog-2005, included by bare name
// Notes:   counts are master clock cycles
`ifndef SAR_ADC_AUTOCAL_MAP_VH
`define SAR_ADC_AUTOCAL_MAP_VH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
// 85,532 cycles from calibrate release to busy low
`define CAL_CYCLES     17'h1_4E1C
`define CAL_CNT_BITS   17
// slot per calibration step; ten slots fit inside the total
`define STEP_CYCLES    14'h2000
`define STEP_CNT_BITS  14
// conversion bits decided after the entry pulse (17 pulses total)
`define CONV_DECIDES   5'h10

// ---------------------------------------------------------------
// widths and layout
// ---------------------------------------------------------------
`define RESULT_BITS    16
`define CAL_BITS       8
`define CAL_STEPS      4'hA
`define STEP_BITS      4
`define OFFSET_SLOT    4'h0
`define SIGN_FLIP      16'h8000

// ---------------------------------------------------------------
// states
// ---------------------------------------------------------------
`define ST_CAL         2'h0
`define ST_IDLE        2'h1
`define ST_CONV        2'h2
`define ST_BITS        2

`endif

// File: tb/sar_adc_autocal_sequencer_assertions.sv
// Purpose: port-level checks of the converter sequencer
// Assumes: calRequest and sys_rst both reset the block asynchronously
// Notes:   calCnt mirrors the calibration length from the outside
`timescale 1ns/1ps
`default_nettype none

module sar_adc_autocal_sequencer_assertions #(
    parameter int CAL_CYCLES  = 85532,
    parameter int STEP_CYCLES = 8192
) (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       calRequest,
    input wire logic       acquire,
    input wire logic       busy,
    input wire logic       serialClk,
    input wire logic       sampleHold,
    input wire logic       groundSenseSel,
    input wire logic       chargeToRef,
    input wire logic [3:0] capSelect,
    input wire logic       resultValid
);
    wire         rst = sys_rst || calRequest;
    logic [16:0] calCnt;

    // saturates so it never wraps into a false second calibration
    always_ff @(posedge clk or posedge rst) begin
        if (rst) calCnt <= 17'h0_0000;
        else if (calCnt < CAL_CYCLES) calCnt <= calCnt + 17'h0_0001;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_reset_holds: assert property (disable iff (1'b0)
        rst |-> busy && !resultValid && !sampleHold)
        else $error("busy low or result valid during reset");
    a_cal_busy_hold: assert property (calCnt < CAL_CYCLES |->
        busy && !resultValid && !sampleHold)
        else $error("busy dropped or conversion inside calibration");
    a_cal_end_edge: assert property (calCnt == CAL_CYCLES &&
        $past(calCnt) != CAL_CYCLES |-> !busy && resultValid)
        else $error("calibration did not end on the counted edge");
    a_offset_step: assert property (calCnt < STEP_CYCLES |->
        groundSenseSel && capSelect == 4'h0)
        else $error("first step not on ground sense");
    a_charge_pulse: assert property (chargeToRef |->
        capSelect != 4'h0 && !groundSenseSel ##1 !chargeToRef)
        else $error("charge pulse malformed");
    a_cap_range: assert property (capSelect <= 4'h9)
        else $error("capacitor select beyond nine");
    a_diag_clock: assert property (acquire [*6] ##0
        calCnt < CAL_CYCLES - 2 |=> serialClk != $past(serialClk))
        else $error("no diagnostic clock with acquire high");
    a_conv_length: assert property ($rose(sampleHold) |->
        busy [*8] ##1 busy [*8] ##1 !busy)
        else $error("conversion busy length wrong");
    a_conv_trigger: assert property ($rose(sampleHold) |->
        resultValid && !$past(acquire, 3) && !$past(acquire, 4))
        else $error("conversion without acquire fall");
endmodule // sar_adc_autocal_sequencer_assertions

bind sar_adc_autocal_sequencer sar_adc_autocal_sequencer_assertions #(
    .CAL_CYCLES(CAL_CYCLES), .STEP_CYCLES(STEP_CYCLES)
) chk_i (
    .clk(clk), .sys_rst(sys_rst), .calRequest(calRequest),
    .acquire(acquire), .busy(busy), .serialClk(serialClk),
    .sampleHold(sampleHold), .groundSenseSel(groundSenseSel),
    .chargeToRef(chargeToRef), .capSelect(capSelect),
    .resultValid(resultValid)
);
`default_nettype wire

// File: tb/sar_analog_model.sv
// Purpose: comparator of the analog array facing the sequencer
// Assumes: answers within the same cycle as the trial word
// Notes:   fixed levels make every run repeatable
`timescale 1ns/1ps
`default_nettype none

module sar_analog_model #(
    parameter logic [7:0] CAL_LEVEL = 8'h5A
) (
    input  wire logic        sampleHold,
    input  wire logic [15:0] dacWord,
    input  wire logic [7:0]  calDacCode,
    input  wire logic [15:0] vin,
    output logic             compHigh
);
    // keep the trial while it stays at or below the held level
    assign compHigh = sampleHold ? (dacWord <= vin)
                                 : (calDacCode <= CAL_LEVEL);
endmodule // sar_analog_model
`default_nettype wire

// File: tb/sar_adc_autocal_sequencer_tb.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: short calibration count, comparator model on the far side
// Notes:   inputs change on the falling clock edge
`timescale 1ns/1ps
`default_nettype none

module sar_adc_autocal_sequencer_tb;
    localparam int CAL = 200;
    logic        clk, sysRst, calRequest, acquire;
    logic [15:0] vin, res, firstRes;
    wire         compHigh, busy, serialData, serialClk, sampleHold;
    wire         resultValid;
    wire  [15:0] resultWord, dacWord;
    wire  [7:0]  calDacCode;
    int          mismatches, compares, n;
    // vin, then result: vin - level, plus level per set bit 15..7, msb flipped
    logic [31:0] rows [4] = '{32'h0000_7FA6, 32'h7FFF_0275,
                              32'hFFFF_82CF, 32'h7FFF_0275};

    sar_adc_autocal_sequencer #(
        .CAL_CYCLES(17'h0_00C8), .STEP_CYCLES(14'h0010)
    ) sar_adc_autocal_sequencer_i (
        .clk(clk), .sys_rst(sysRst), .calRequest(calRequest),
        .acquire(acquire), .compHigh(compHigh), .busy(busy),
        .serial_data_out(serialData), .serialClk(serialClk),
        .sampleHold(sampleHold), .groundSenseSel(), .chargeToRef(),
        .capSelect(), .calDacCode(calDacCode), .dacWord(dacWord),
        .resultWord(resultWord), .resultValid(resultValid)
    );
    sar_analog_model #(
        .CAL_LEVEL(8'h5A)
    ) sar_analog_model_i (
        .sampleHold(sampleHold), .dacWord(dacWord),
        .calDacCode(calDacCode), .vin(vin), .compHigh(compHigh)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // release reset, count edges to busy low; with diag set, acquire falls mid-run
    task automatic cal_run(input logic diag);
        logic p;
        int   tog;
        @(negedge clk);
        acquire = diag;
        sysRst = 1'b0;
        calRequest = 1'b0;
        n = 0;
        tog = 0;
        p = serialClk;
        while (busy === 1'b1 && n < CAL + 10) begin
            @(negedge clk);
            n++;
            if (serialClk !== p) tog++;
            p = serialClk;
            if (n == CAL / 2) acquire = 1'b0;
        end
        check(n, CAL);
        check(resultValid, 1'b1);
        if (diag) check(tog > 0, 1'b1);
        if (n >= CAL + 10) test_done();
    endtask

    task automatic convert(input logic [15:0] v, input logic [15:0] e,
                           output logic [15:0] r);
        logic p;
        int   k;
        @(negedge clk);
        vin = v;
        acquire = 1'b1;
        repeat (4) @(negedge clk);
        acquire = 1'b0;
        for (k = 0; busy !== 1'b1 && k < 20; k++) @(negedge clk);
        for (n = 0; busy === 1'b1 && n < 40; n++) @(negedge clk);
        check(n, 16);
        r = 16'h0000;
        p = serialClk;
        for (k = 0; k < 16 && n < 120; n++) begin
            if (serialClk === 1'b1 && p !== 1'b1) begin
                r = {r[14:0], serialData};
                k++;
            end
            p = serialClk;
            @(negedge clk);
        end
        check(r, e);
        check(resultWord, e);
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        mismatches = 0;
        compares = 0;
        sysRst = 1'b0;
        calRequest = 1'b0;
        acquire = 1'b0;
        vin = 16'h0000;
        // a clean edge once every process waits on it
        #1 sysRst = 1'b1;
        repeat (4) @(negedge clk);
        check(busy, 1'b1);
        check(resultValid, 1'b0);
        cal_run(1'b0);
        $display("test power-up calibration done");
        for (int i = 0; i < 4; i++) begin
            convert(rows[i][31:16], rows[i][15:0], res);
            if (i == 1) firstRes = res;
        end
        check(res, firstRes);
        $display("test conversion rows done");
        // ---------------------------------------------------------------
        // aborts: calibration, then conversion, both mid-run
        // ---------------------------------------------------------------
        @(negedge clk) calRequest = 1'b1;
        @(negedge clk) calRequest = 1'b0;
        repeat (50) @(negedge clk);
        calRequest = 1'b1;
        #1 check(busy, 1'b1);
        cal_run(1'b0);
        vin = 16'h7FFF;
        acquire = 1'b1;
        repeat (4) @(negedge clk);
        acquire = 1'b0;
        repeat (8) @(negedge clk);
        calRequest = 1'b1;
        #1 check({busy, sampleHold, resultValid}, 3'b100);
        cal_run(1'b1);
        convert(16'h7FFF, 16'h0275, res);
        check(res, firstRes);
        $display("test abort and diagnostic done");
        test_done();
    end
endmodule // sar_adc_autocal_sequencer_tb
`default_nettype wire
